// >>> uesf_endpoint.sv
// endpoint flag, toggle and bank logic with an Avalon-MM register slave
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`default_nettype none

module uesf_endpoint (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic [4:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output var  logic [31:0]           readdata,
    output var  logic                  waitrequest,
    input  wire logic                  in_token,
    input  wire logic                  out_packet,
    input  wire logic [1:0]            out_pid,
    input  wire logic                  out_is_setup,
    input  wire logic                  out_short,
    input  wire logic                  out_crc_bad,
    input  wire logic                  out_too_big,
    input  wire logic                  in_dma_end,
    input  wire logic                  uframe_end,
    output var  logic                  reply_valid,
    output var  uesf_pkg::uesf_reply_t reply_code,
    output var  logic [1:0]            reply_pid,
    output var  logic                  flush_banks,
    output var  logic                  endpoint_irq
);
    import uesf_pkg::*;

    function automatic logic [1:0] hb_in_pid(input logic [1:0] left);
        case (left)
            2'h1:    hb_in_pid = PID_DATA0;
            2'h2:    hb_in_pid = PID_DATA1;
            default: hb_in_pid = PID_DATA2;
        endcase
    endfunction

    function automatic logic [1:0] sat_inc(input logic [1:0] v);
        sat_inc = (v == 2'h3) ? v : v + 2'h1;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]  flag;
    logic [1:0]  toggle_pid_field;
    logic [1:0]  busy;
    logic        stall_request;
    logic [9:0]  enable_reg;
    logic [7:0]  config_reg;
    logic [1:0]  done_cnt;
    logic [1:0]  fill_cnt;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    uesf_ep_t    ep_type;
    logic        is_ctrl;
    logic        is_iso;
    logic        dir_in;
    logic        hb_iso;
    logic        hb_in;
    logic [1:0]  ntrans;
    logic [1:0]  cap;
    logic        bank_control_flag;
    logic        wr_go;
    logic [31:0] wd;
    logic [7:0]  clr_vec;
    logic [7:0]  set_vec;
    logic [2:0]  cmd_vec;
    logic [7:0]  flag_mask;

    assign ep_type = uesf_ep_t'(config_reg[CF_TYPE +: 2]);
    assign is_ctrl = (ep_type == EP_CTRL);
    assign is_iso  = (ep_type == EP_ISO);
    assign dir_in  = config_reg[CF_DIR_IN] & ~is_ctrl;
    assign ntrans  = config_reg[CF_NTRANS +: 2];
    assign hb_iso  = config_reg[CF_HB] & is_iso;
    assign hb_in   = hb_iso & dir_in & (ntrans >= 2'h2);
    assign cap     = is_ctrl ? BANKS_CTRL : BANKS_DATA;
    // IN: a free bank to fill; OUT: a full bank to read
    assign bank_control_flag = dir_in ? (busy < cap) : (busy != 2'h0);

    assign wr_go = write & ~waitrequest;
    assign wd = writedata & {{8{byteenable[3]}}, {8{byteenable[2]}},
                             {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign clr_vec = (wr_go && address == OFF_CLEAR) ? wd[7:0] : 8'h00;
    assign set_vec = (wr_go && address == OFF_SET) ? wd[7:0] : 8'h00;
    assign cmd_vec = (wr_go && address == OFF_COMMAND) ? wd[2:0] : 3'h0;

    // shared bit is dead on bulk/interrupt, out flag dead on IN
    always_comb begin
        flag_mask = 8'hFE;
        flag_mask[FB_SETUP]  = is_ctrl | is_iso;
        flag_mask[FB_OUT_RX] = ~dir_in;
    end

    // ----------------------------------------------------------------
    // transaction decisions
    // ----------------------------------------------------------------
    logic [7:0]  ev;
    logic        rsp_v;
    uesf_reply_t rsp;
    logic [1:0]  rsp_pid;
    logic [1:0]  next_toggle;
    logic [1:0]  next_busy;
    logic [1:0]  next_done;
    logic [1:0]  next_fill;
    logic        inc;
    logic        dec;
    logic        do_flush;

    always_comb begin
        ev = 8'h00;
        rsp_v = 1'b0;
        rsp = REPLY_ACK;
        rsp_pid = toggle_pid_field;
        next_toggle = toggle_pid_field;
        next_done = done_cnt;
        next_fill = fill_cnt;
        inc = 1'b0;
        dec = 1'b0;
        do_flush = 1'b0;
        if (in_token) begin
            rsp_v = 1'b1;
            if (stall_request) begin
                rsp = REPLY_STALL;
                ev[FB_STALL] = 1'b1;
            end else if (busy != 2'h0) begin
                rsp = REPLY_DATA;
                if (hb_iso)
                    rsp_pid = hb_in_pid(2'(ntrans - done_cnt));
                else if (toggle_pid_field == PID_DATA0)
                    rsp_pid = PID_DATA1;
                else
                    rsp_pid = PID_DATA0;
                next_toggle = rsp_pid;
                dec = 1'b1;
                next_done = sat_inc(done_cnt);
            end else if (is_iso) begin
                rsp = REPLY_ZLP;
                ev[FB_SETUP] = 1'b1;
            end else begin
                rsp = REPLY_NAK;
                ev[FB_NAKIN] = 1'b1;
            end
        end else if (out_packet) begin
            rsp_v = 1'b1;
            if (out_is_setup && is_ctrl) begin
                // a setup always lands; it overrides a pending stall
                ev[FB_SETUP] = 1'b1;
                inc = (busy == 2'h0);
                next_toggle = out_pid;
            end else if (stall_request) begin
                rsp = REPLY_STALL;
                ev[FB_STALL] = 1'b1;
            end else if (busy >= cap) begin
                if (is_iso) begin
                    rsp = REPLY_DROP;
                    ev[FB_SETUP] = 1'b1;
                end else begin
                    rsp = REPLY_NAK;
                    ev[FB_NAKOUT] = 1'b1;
                end
            end else begin
                inc = 1'b1;
                next_toggle = out_pid;
                ev[FB_OUT_RX] = 1'b1;
                ev[FB_SHORT] = out_short & ~is_ctrl;
                ev[FB_STALL] = out_crc_bad & is_iso;
                ev[FB_OVERRUN] = out_too_big;
            end
        end else if (in_dma_end && dir_in && config_reg[CF_DMA_END]
                     && config_reg[CF_AUTO_SW]) begin
            rsp_v = 1'b1;
            rsp = REPLY_SHORT;
            ev[FB_SHORT] = 1'b1;
        end
        // software frees or hands over the current bank
        if (cmd_vec[CMD_BANK_FREE] && !is_ctrl) begin
            if (dir_in && busy < cap && !inc) begin
                inc = 1'b1;
                next_fill = sat_inc(fill_cnt);
            end else if (!dir_in && busy != 2'h0 && !dec) begin
                dec = 1'b1;
                // next bank already full: the out flag follows it
                ev[FB_OUT_RX] = ev[FB_OUT_RX] | (busy > 2'h1);
            end
        end
        if (is_ctrl && !dec && busy != 2'h0
            && (clr_vec[FB_SETUP] || clr_vec[FB_OUT_RX]))
            dec = 1'b1;
        if (uframe_end && hb_in) begin
            if (done_cnt < ntrans) begin
                do_flush = 1'b1;
                ev[FB_NAKIN] = 1'b1;
            end
            ev[FB_NAKOUT] = ev[FB_NAKOUT] | (fill_cnt < ntrans);
            next_done = 2'h0;
            next_fill = 2'h0;
        end
        if (do_flush)
            next_busy = 2'h0;
        else
            next_busy = 2'(busy + {1'b0, inc} - {1'b0, dec});
    end

    // ----------------------------------------------------------------
    // flags: hardware set wins over software clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b)
            flag <= 8'h00;
        else
            flag <= ((flag & ~clr_vec) | ev | set_vec) & flag_mask;
    end

    always_ff @(posedge clock) begin
        if (!rst_b)
            toggle_pid_field <= TOGGLE_RESET;
        else
            toggle_pid_field <= next_toggle;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            busy <= 2'h0;
            done_cnt <= 2'h0;
            fill_cnt <= 2'h0;
        end else begin
            busy <= next_busy;
            done_cnt <= next_done;
            fill_cnt <= next_fill;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b)
            stall_request <= 1'b0;
        else if (cmd_vec[CMD_STALL_SET])
            stall_request <= 1'b1;
        else if (cmd_vec[CMD_STALL_CLR] || (out_packet && out_is_setup))
            stall_request <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
            reply_code <= REPLY_ACK;
            reply_pid <= PID_DATA0;
            flush_banks <= 1'b0;
        end else begin
            reply_valid <= rsp_v;
            reply_code <= rsp;
            reply_pid <= rsp_pid;
            flush_banks <= do_flush;
        end
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    logic [7:0] pend;
    logic       hb_out_hit;

    assign hb_out_hit = flag[FB_OUT_RX] & hb_iso & ~dir_in &
        ((enable_reg[EN_MDATA] & toggle_pid_field == PID_MDATA) |
         (enable_reg[EN_DATAX] & toggle_pid_field != PID_MDATA));

    always_comb begin
        pend = flag & enable_reg[7:0];
        if (hb_iso && !dir_in)
            pend[FB_OUT_RX] = hb_out_hit;
    end

    always_ff @(posedge clock) begin
        if (!rst_b)
            endpoint_irq <= 1'b0;
        else
            endpoint_irq <= |pend;
    end

    // ----------------------------------------------------------------
    // register slave: one wait cycle, then the access is taken
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b)
            waitrequest <= 1'b1;
        else
            waitrequest <= ~((read | write) & waitrequest);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            enable_reg <= ENABLE_RESET;
            config_reg <= CONFIG_RESET;
        end else if (wr_go && address == OFF_ENABLE) begin
            enable_reg <= {wd[9:1], 1'b0};
        end else if (wr_go && address == OFF_CONFIG) begin
            config_reg <= wd[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= 32'h0000_0000;
            case (address)
                OFF_STATUS: begin
                    readdata[7:0] <= flag;
                    readdata[ST_TOGGLE +: 2] <= toggle_pid_field;
                    readdata[ST_BUSY +: 2] <= busy;
                    readdata[ST_BANKCTL] <= bank_control_flag;
                    readdata[ST_STALL_REQUEST] <= stall_request;
                end
                OFF_ENABLE: readdata[9:0] <= enable_reg;
                OFF_CONFIG: readdata[7:0] <= config_reg;
                default:    readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_toggle_reset: assert property (@(posedge clock)
        $rose(rst_b) |-> toggle_pid_field == PID_DATA1)
        else $error("toggle field not Data1 after reset");

    a_in_next_pid: assert property (@(posedge clock) disable iff (!rst_b)
        in_token && !stall_request && busy != 2'h0 && !hb_iso
        |=> reply_code == REPLY_DATA && reply_pid != $past(toggle_pid_field)
            && toggle_pid_field == reply_pid)
        else $error("IN packet did not use the next toggle");

    a_out_last_pid: assert property (@(posedge clock) disable iff (!rst_b)
        out_packet && !out_is_setup && !stall_request && busy < cap
        |=> toggle_pid_field == $past(out_pid) && flag[FB_OUT_RX])
        else $error("OUT PID not recorded");

    a_short_out: assert property (@(posedge clock) disable iff (!rst_b)
        out_packet && out_short && !stall_request && busy < cap
        && !is_ctrl && !out_is_setup |=> flag[FB_SHORT])
        else $error("short packet flag missing");

    a_irq_follows: assert property (@(posedge clock) disable iff (!rst_b)
        flag[FB_OVERRUN] && enable_reg[FB_OVERRUN]
        |=> endpoint_irq)
        else $error("enabled flag gave no interrupt");

    a_clear_flag: assert property (@(posedge clock) disable iff (!rst_b)
        clr_vec[FB_NAKIN] && !ev[FB_NAKIN] && !set_vec[FB_NAKIN]
        |=> !flag[FB_NAKIN])
        else $error("write-one clear had no effect");

    a_stall_reply: assert property (@(posedge clock) disable iff (!rst_b)
        in_token && stall_request
        |=> reply_valid && reply_code == REPLY_STALL && flag[FB_STALL])
        else $error("stall not sent or not flagged");

    a_nak_in: assert property (@(posedge clock) disable iff (!rst_b)
        in_token && !stall_request && busy == 2'h0 && !is_iso
        |=> reply_code == REPLY_NAK && flag[FB_NAKIN])
        else $error("NAK to IN not flagged");

    a_iso_drop: assert property (@(posedge clock) disable iff (!rst_b)
        out_packet && is_iso && !stall_request && busy >= cap
        |=> reply_code == REPLY_DROP && flag[FB_SETUP]
            && busy == $past(busy))
        else $error("iso OUT into full bank not dropped");

    a_hb_flush: assert property (@(posedge clock) disable iff (!rst_b)
        uframe_end && hb_in && done_cnt < ntrans
        |=> flush_banks && busy == 2'h0 && flag[FB_NAKIN])
        else $error("hb IN banks not flushed");
endmodule
`default_nettype wire

// >>> uesf_pkg.sv
// package: register map, field positions and codes of the endpoint flags
`default_nettype none
package uesf_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFF_STATUS  = 5'h00;
    localparam logic [4:0] OFF_CLEAR   = 5'h04;
    localparam logic [4:0] OFF_SET     = 5'h08;
    localparam logic [4:0] OFF_ENABLE  = 5'h0C;
    localparam logic [4:0] OFF_COMMAND = 5'h10;
    localparam logic [4:0] OFF_CONFIG  = 5'h14;

    // ----------------------------------------------------------------
    // flag bits, shared by status, clear, set and enable registers
    // ----------------------------------------------------------------
    localparam int FB_OUT_RX   = 1;  // out received
    localparam int FB_SETUP    = 2;  // setup received / bank starve
    localparam int FB_NAKOUT   = 3;  // nak out / hb in starve
    localparam int FB_NAKIN    = 4;  // nak in / hb flush
    localparam int FB_OVERRUN  = 5;
    localparam int FB_STALL    = 6;  // stall sent / crc fail
    localparam int FB_SHORT    = 7;

    // status fields
    localparam int ST_TOGGLE   = 8;
    localparam int ST_BUSY     = 12;
    localparam int ST_BANKCTL  = 14;
    localparam int ST_STALL_REQUEST  = 19;
    // enable register extras
    localparam int EN_MDATA    = 8;
    localparam int EN_DATAX    = 9;
    // command strobes
    localparam int CMD_STALL_SET = 0;
    localparam int CMD_STALL_CLR = 1;
    localparam int CMD_BANK_FREE = 2;
    // configuration fields
    localparam int CF_TYPE     = 0;
    localparam int CF_DIR_IN   = 2;
    localparam int CF_HB       = 3;
    localparam int CF_NTRANS   = 4;
    localparam int CF_DMA_END  = 6;
    localparam int CF_AUTO_SW  = 7;

    // ----------------------------------------------------------------
    // codes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] PID_DATA0 = 2'h0;
    localparam logic [1:0] PID_DATA1 = 2'h1;
    localparam logic [1:0] PID_DATA2 = 2'h2;
    localparam logic [1:0] PID_MDATA = 2'h3;
    localparam logic [1:0] TOGGLE_RESET = PID_DATA1;
    localparam logic [1:0] BANKS_DATA   = 2'h2;
    localparam logic [1:0] BANKS_CTRL   = 2'h1;
    localparam logic [9:0] ENABLE_RESET = 10'h000;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    typedef enum logic [1:0] {
        EP_CTRL = 2'h0,
        EP_ISO  = 2'h1,
        EP_BULK = 2'h2,
        EP_INTR = 2'h3
    } uesf_ep_t;

    typedef enum logic [2:0] {
        REPLY_ACK   = 3'h0,
        REPLY_NAK   = 3'h1,
        REPLY_STALL = 3'h2,
        REPLY_DATA  = 3'h3,
        REPLY_ZLP   = 3'h4,
        REPLY_DROP  = 3'h5,
        REPLY_SHORT = 3'h6
    } uesf_reply_t;
endpackage
`default_nettype wire

// >>> uesf_host.sv
// usb host model that drives the endpoint engine strobes
`default_nettype none
module uesf_host (
    input  wire logic       clock,
    output var  logic       in_token,
    output var  logic       out_packet,
    output var  logic [1:0] out_pid,
    output var  logic [3:0] out_attr,
    output var  logic       in_dma_end,
    output var  logic       uframe_end,
    input  wire logic       reply_valid,
    input  wire logic [2:0] reply_code,
    input  wire logic [1:0] reply_pid,
    input  wire logic       flush_banks
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] last_code;
    logic [1:0] last_pid;
    logic       flush_seen;
    initial begin
        {in_token, out_packet, in_dma_end, uframe_end} = 4'h0;
        out_pid = 2'h0;
        out_attr = 4'h0;
    end
    // op: 0 in token, 1 data packet, 2 dma end, 3 micro-frame end
    task automatic send(input logic [1:0] op, input logic [1:0] pid,
                        input logic [3:0] attr);
        @(posedge clock);
        last_code  <= 3'h7;
        flush_seen <= 1'b0;
        in_token   <= (op == 2'h0);
        out_packet <= (op == 2'h1);
        in_dma_end <= (op == 2'h2);
        uframe_end <= (op == 2'h3);
        out_pid    <= pid;
        out_attr   <= attr;
        @(posedge clock);
        {in_token, out_packet, in_dma_end, uframe_end} <= 4'h0;
        // released data lines must not keep looking valid
        out_pid    <= ~pid;
        out_attr   <= ~attr;
    endtask
    always @(posedge clock) begin
        if (reply_valid === 1'b1) begin
            last_code <= reply_code;
            last_pid  <= reply_pid;
        end
        if (flush_banks === 1'b1) begin
            flush_seen <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> uesf_endpoint_tb_top.sv
// self-checking bench for the endpoint flag logic
`default_nettype none
module uesf_endpoint_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uesf_pkg::*;
    logic        clock, rst_b, read, write, waitrequest;
    logic        in_token, out_packet, in_dma_end, uframe_end;
    logic        reply_valid, flush_banks, endpoint_irq;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rdata;
    logic [1:0]  out_pid, reply_pid;
    logic [3:0]  out_attr;
    uesf_reply_t reply_code;
    int          miscompares = 0;
    int          compares = 0;
    // ------------------------------------------------------------
    // table of single-event cases
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [9:0] en;
        logic [1:0] op;
        logic [1:0] pid;
        logic [3:0] attr;   // setup, short, crc bad, too big
        logic [7:0] flags;
        logic [2:0] reply;  // 7: no handshake compared
        logic       irq;
    } uesf_row_t;
    uesf_row_t rows [13] = '{
        '{8'h02, 10'h002, 2'h1, 2'h0, 4'h4, 8'h82, 3'h0, 1'b1},
        '{8'h06, 10'h000, 2'h0, 2'h0, 4'h0, 8'h10, 3'h1, 1'b0},
        '{8'h00, 10'h004, 2'h1, 2'h0, 4'h8, 8'h04, 3'h0, 1'b1},
        '{8'h01, 10'h000, 2'h1, 2'h0, 4'h2, 8'h42, 3'h0, 1'b0},
        '{8'h02, 10'h020, 2'h1, 2'h0, 4'h1, 8'h22, 3'h0, 1'b1},
        '{8'h05, 10'h004, 2'h0, 2'h0, 4'h0, 8'h04, 3'h4, 1'b1},
        '{8'h09, 10'h100, 2'h1, 2'h3, 4'h0, 8'h02, 3'h0, 1'b1},
        '{8'h09, 10'h100, 2'h1, 2'h0, 4'h0, 8'h02, 3'h0, 1'b0},
        '{8'h09, 10'h200, 2'h1, 2'h2, 4'h0, 8'h02, 3'h0, 1'b1},
        '{8'h00, 10'h002, 2'h1, 2'h0, 4'h0, 8'h02, 3'h0, 1'b1},
        '{8'hC6, 10'h080, 2'h2, 2'h0, 4'h0, 8'h80, 3'h6, 1'b1},
        '{8'h46, 10'h080, 2'h2, 2'h0, 4'h0, 8'h00, 3'h7, 1'b0},
        '{8'h2D, 10'h018, 2'h3, 2'h0, 4'h0, 8'h18, 3'h7, 1'b1}
    };
    uesf_endpoint DUT (.clock(clock), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .in_token(in_token),
        .out_packet(out_packet), .out_pid(out_pid),
        .out_is_setup(out_attr[3]), .out_short(out_attr[2]),
        .out_crc_bad(out_attr[1]), .out_too_big(out_attr[0]),
        .in_dma_end(in_dma_end), .uframe_end(uframe_end),
        .reply_valid(reply_valid), .reply_code(reply_code),
        .reply_pid(reply_pid), .flush_banks(flush_banks),
        .endpoint_irq(endpoint_irq));
    uesf_host host (.clock(clock), .in_token(in_token),
        .out_packet(out_packet), .out_pid(out_pid), .out_attr(out_attr),
        .in_dma_end(in_dma_end), .uframe_end(uframe_end),
        .reply_valid(reply_valid), .reply_code(reply_code),
        .reply_pid(reply_pid), .flush_banks(flush_banks));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic reset_dut();
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        // first request only after the first edge with reset high
        @(posedge clock);
    endtask
    // request rises just after an edge and stands until the edge at
    // which waitrequest is sampled low; read data is taken there too
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        address   <= a;
        write     <= wr;
        read      <= ~wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        if (n >= 64) check(32'h1, 32'h0);
        rdata = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // one idle edge, so a following call never re-raises the
        // request in the time step that lowered it
        @(posedge clock);
    endtask
    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        test_done();
    end
    initial begin
        {rst_b, read, write} = 3'h0;
        address = 5'h00;
        writedata = 32'h0;
        foreach (rows[i]) begin
            reset_dut();
            bus(1'b1, OFF_CONFIG, {24'h0, rows[i].cfg});
            bus(1'b1, OFF_ENABLE, {22'h0, rows[i].en});
            host.send(rows[i].op, rows[i].pid, rows[i].attr);
            repeat (3) @(posedge clock);
            check(endpoint_irq, rows[i].irq);
            bus(1'b0, OFF_STATUS, 32'h0);
            check(rdata[7:1], rows[i].flags[7:1]);
            if (rows[i].reply != 3'h7) check(host.last_code, rows[i].reply);
            if (rows[i].op == 2'h1) check(rdata[9:8], rows[i].pid);
            if (rows[i].op == 2'h3) check(host.flush_seen, 1'b1);
            $display("row %0d done", i);
        end
        reset_dut();
        bus(1'b0, OFF_STATUS, 32'h0);
        check(rdata, 32'h0000_0100);
        bus(1'b0, OFF_ENABLE, 32'h0);
        check(rdata, 32'h0);
        bus(1'b0, 5'h18, 32'h0);
        check(rdata, 32'h0);
        $display("reset values done");
        reset_dut();
        bus(1'b1, OFF_CONFIG, 32'h06);
        bus(1'b1, OFF_ENABLE, 32'h40);
        bus(1'b1, OFF_COMMAND, 32'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        check(rdata[19], 1'b1);
        host.send(2'h0, 2'h0, 4'h0);
        bus(1'b0, OFF_STATUS, 32'h0);
        check({host.last_code, rdata[6], endpoint_irq}, 5'b01011);
        bus(1'b1, OFF_CLEAR, 32'h40);
        repeat (3) @(posedge clock);
        check(endpoint_irq, 1'b0);
        bus(1'b1, OFF_COMMAND, 32'h2);
        bus(1'b1, OFF_SET, 32'h20);
        bus(1'b0, OFF_STATUS, 32'h0);
        check({rdata[19], rdata[5]}, 2'b01);
        $display("stall done");
        for (int k = 0; k < 2; k++) begin
            reset_dut();
            bus(1'b1, OFF_CONFIG, k ? 32'h01 : 32'h02);
            repeat (3) host.send(2'h1, 2'h0, 4'h0);
            repeat (2) @(posedge clock);
            check(host.last_code, k ? 3'h5 : 3'h1);
            bus(1'b0, OFF_STATUS, 32'h0);
            check(rdata[3:2], k ? 2'b01 : 2'b10);
            // out flag first, then bank, in that order only
            bus(1'b1, OFF_CLEAR, 32'h02);
            bus(1'b0, OFF_STATUS, 32'h0);
            check({rdata[14], rdata[1]}, 2'b10);
            bus(1'b1, OFF_COMMAND, 32'h4);
            repeat (3) @(posedge clock);
            bus(1'b0, OFF_STATUS, 32'h0);
            check({rdata[14], rdata[1]}, 2'b11);
            $display("full bank case %0d done", k);
        end
        reset_dut();
        bus(1'b1, OFF_CONFIG, 32'h06);
        bus(1'b1, OFF_COMMAND, 32'h4);
        bus(1'b1, OFF_COMMAND, 32'h4);
        for (int j = 0; j < 2; j++) begin
            host.send(2'h0, 2'h0, 4'h0);
            repeat (2) @(posedge clock);
            check({host.last_code, host.last_pid}, {3'h3, 2'(j)});
        end
        $display("in toggle done");
        test_done();
    end
endmodule
`default_nettype wire
